// ### common/acbc_params.svh
// Constants for the accumulator add and bit-clear datapath
`ifndef ACBC_PARAMS_SVH
`define ACBC_PARAMS_SVH
`define ACBC_ADDR_CTRL    12'h000
`define ACBC_ADDR_OPCODE  12'h004
`define ACBC_ADDR_FILEDAT 12'h008
`define ACBC_ADDR_ACC     12'h00c
`define ACBC_ADDR_STATUS  12'h010
`define ACBC_ADDR_RESULT  12'h014
`define ACBC_CTRL_GO_BIT  0
`define ACBC_ST_C_BIT     0
`define ACBC_ST_HALF_BIT  1
`define ACBC_ST_Z_BIT     2
`define ACBC_ST_WE_BIT    3
`define ACBC_ST_DONE_BIT  4
`define ACBC_OP_ADDLIT    5'h1f
`define ACBC_OP_ANDLIT    6'h39
`define ACBC_OP_ADDFILE   6'h07
`define ACBC_OP_ANDFILE   6'h05
`define ACBC_OP_CLRBIT    4'h4
`define ACBC_ACC_RESET    8'h00
`endif

// ### common/acbc_pkg.sv
// Types for the accumulator add and bit-clear datapath
package acbc_pkg;
  typedef enum logic [5:0] {
    ACBC_NONE    = 6'h01,
    ACBC_ADD_LIT = 6'h02,
    ACBC_AND_LIT = 6'h04,
    ACBC_ADD_F   = 6'h08,
    ACBC_AND_F   = 6'h10,
    ACBC_CLR_BIT = 6'h20
  } acbc_op_t;
endpackage

// ### core/acbc_alu.sv
// Combinational ALU core for add, and, bit clear
`timescale 1ns/10ps
`default_nettype none
module acbc_alu
  import acbc_pkg::*;
(
  input  wire acbc_op_t   op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] lit,
  input  wire logic [7:0] fval,
  input  wire logic [2:0] bsel,
  output logic      [7:0] res,
  output logic            c,
  output logic            half_c,
  output logic            z
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] opb;
  always_comb begin
    opb = (op == ACBC_ADD_LIT || op == ACBC_AND_LIT) ? lit : fval;
    sum = {1'b0, acc} + {1'b0, opb};
    nib = {1'b0, acc[3:0]} + {1'b0, opb[3:0]};
    c   = sum[8];
    half_c = nib[4];
    case (op)
      ACBC_ADD_LIT, ACBC_ADD_F: res = sum[7:0];
      ACBC_AND_LIT, ACBC_AND_F: res = acc & opb;
      ACBC_CLR_BIT:             res = fval & ~(8'h01 << bsel);
      default:                  res = acc;
    endcase
    z = (res == 8'h00);
  end
endmodule
`default_nettype wire

// ### core/acbc_core.sv
// Accumulator add/and/bit-clear execute datapath with APB access
`timescale 1ns/10ps
`include "acbc_params.svh"
`default_nettype none
module acbc_core
  import acbc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [13:0] opcode,
  input  wire logic        op_valid,
  input  wire logic [7:0]  file_rdata,
  input  wire logic        file_is_port,
  input  wire logic [7:0]  port_pins,
  output logic      [6:0]  file_addr,
  output logic      [7:0]  file_wdata,
  output logic             file_we,
  output logic      [7:0]  acc_out,
  output logic             carry_flag,
  output logic             digit_carry_flag,
  output logic             zero_flag
);
  logic [13:0] opc_reg, opc_next;
  logic [7:0]  fdat_reg, fdat_next;
  logic [7:0]  acc_reg, acc_next;
  logic        c_reg, c_next;
  logic        half_c_reg, half_c_next;
  logic        z_reg, z_next;
  logic [6:0]  fa_reg, fa_next;
  logic [7:0]  fw_reg, fw_next;
  logic        we_reg, we_next;
  logic        done_reg, done_next;
  logic [31:0] rd_reg, rd_next;
  logic [7:0]  pin_s1_reg, pin_s2_reg;
  acbc_op_t    op;
  logic [13:0] opw;
  logic [7:0]  res;
  logic [7:0]  fsrc;
  logic        ac, ahc, az;
  logic        go, wr, rd, dsel;

  function automatic acbc_op_t decode(input logic [13:0] o);
    if (o[13:9] == `ACBC_OP_ADDLIT)
      decode = ACBC_ADD_LIT;
    else if (o[13:8] == `ACBC_OP_ANDLIT)
      decode = ACBC_AND_LIT;
    else if (o[13:8] == `ACBC_OP_ADDFILE)
      decode = ACBC_ADD_F;
    else if (o[13:8] == `ACBC_OP_ANDFILE)
      decode = ACBC_AND_F;
    else if (o[13:10] == `ACBC_OP_CLRBIT)
      decode = ACBC_CLR_BIT;
    else
      decode = ACBC_NONE;
  endfunction

  // Pins are asynchronous, so synchronise before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= port_pins;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign wr = psel && penable && pwrite;
  // Reads captured in setup, so prdata leaves a flop with no wait state
  assign rd = psel && !penable && !pwrite;
  assign go = (wr && paddr == `ACBC_ADDR_CTRL &&
               pwdata[`ACBC_CTRL_GO_BIT]) || op_valid;
  // Pipeline word wins over the stored word when both ask at once
  assign opw = op_valid ? opcode : opc_reg;
  assign op = decode(opw);
  assign dsel = opw[7];
  // Port reads take pin level, not output latch
  assign fsrc = file_is_port ? pin_s2_reg :
                (op_valid ? file_rdata : fdat_reg);

  acbc_alu u_alu (
    .op     (op),
    .acc    (acc_reg),
    .lit    (opw[7:0]),
    .fval   (fsrc),
    .bsel   (opw[9:7]),
    .res    (res),
    .c      (ac),
    .half_c (ahc),
    .z      (az)
  );

  always_comb begin
    opc_next  = opc_reg;
    fdat_next = fdat_reg;
    acc_next  = acc_reg;
    c_next    = c_reg;
    half_c_next = half_c_reg;
    z_next    = z_reg;
    fa_next   = fa_reg;
    fw_next   = fw_reg;
    we_next   = 1'b0;
    done_next = done_reg;
    if (wr && paddr == `ACBC_ADDR_OPCODE)
      opc_next = pwdata[13:0];
    if (wr && paddr == `ACBC_ADDR_FILEDAT)
      fdat_next = pwdata[7:0];
    if (wr && paddr == `ACBC_ADDR_ACC)
      acc_next = pwdata[7:0];
    if (go) begin
      // Sticky, so software can tell that at least one execute ran
      done_next = 1'b1;
      fa_next   = opw[6:0];
      case (op)
        ACBC_ADD_LIT, ACBC_ADD_F: begin
          c_next  = ac;
          half_c_next = ahc;
          z_next  = az;
        end
        ACBC_AND_LIT, ACBC_AND_F: begin
          z_next = az;
        end
        default: begin
        end
      endcase
      case (op)
        ACBC_ADD_LIT, ACBC_AND_LIT: acc_next = res;
        ACBC_ADD_F, ACBC_AND_F: begin
          if (dsel) begin
            fw_next = res;
            we_next = 1'b1;
          end else begin
            acc_next = res;
          end
        end
        ACBC_CLR_BIT: begin
          fw_next = res;
          we_next = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // An execute in the setup cycle shows up on the next read only
  always_comb begin
    rd_next = rd_reg;
    if (rd) begin
      rd_next = 32'h00000000;
      case (paddr)
        `ACBC_ADDR_OPCODE:  rd_next[13:0] = opc_reg;
        `ACBC_ADDR_FILEDAT: rd_next[7:0] = fdat_reg;
        `ACBC_ADDR_ACC:     rd_next[7:0] = acc_reg;
        `ACBC_ADDR_STATUS: begin
          rd_next[`ACBC_ST_C_BIT]    = c_reg;
          rd_next[`ACBC_ST_HALF_BIT] = half_c_reg;
          rd_next[`ACBC_ST_Z_BIT]    = z_reg;
          rd_next[`ACBC_ST_WE_BIT]   = we_reg;
          rd_next[`ACBC_ST_DONE_BIT] = done_reg;
        end
        `ACBC_ADDR_RESULT:  rd_next[14:0] = {fa_reg, fw_reg};
        default:            rd_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opc_reg  <= 14'h0000;
      fdat_reg <= 8'h00;
      acc_reg  <= `ACBC_ACC_RESET;
      c_reg    <= 1'b0;
      half_c_reg <= 1'b0;
      z_reg    <= 1'b0;
      fa_reg   <= 7'h00;
      fw_reg   <= 8'h00;
      we_reg   <= 1'b0;
      done_reg <= 1'b0;
      rd_reg   <= 32'h00000000;
    end else begin
      opc_reg  <= opc_next;
      fdat_reg <= fdat_next;
      acc_reg  <= acc_next;
      c_reg    <= c_next;
      half_c_reg <= half_c_next;
      z_reg    <= z_next;
      fa_reg   <= fa_next;
      fw_reg   <= fw_next;
      we_reg   <= we_next;
      done_reg <= done_next;
      rd_reg   <= rd_next;
    end
  end

  // Zero-wait slave; read data registered from setup phase address
  assign prdata = rd_reg;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign file_addr = fa_reg;
  assign file_wdata = fw_reg;
  assign file_we = we_reg;
  assign acc_out = acc_reg;
  assign carry_flag = c_reg;
  assign digit_carry_flag = half_c_reg;
  assign zero_flag = z_reg;
endmodule
`default_nettype wire

// ### test/acbc_core_sva.sv
// Checker on the execute datapath ports
`timescale 1ns/10ps
`default_nettype none
module acbc_core_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [13:0] opcode,
  input wire logic        op_valid,
  input wire logic [7:0]  file_rdata,
  input wire logic        file_is_port,
  input wire logic [6:0]  file_addr,
  input wire logic [7:0]  file_wdata,
  input wire logic        file_we,
  input wire logic [7:0]  acc_out,
  input wire logic        carry_flag,
  input wire logic        digit_carry_flag,
  input wire logic        zero_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Port operands lag through the synchroniser, so the operand checks take plain files only
  wire       g = op_valid & ~file_is_port;
  wire [7:0] k = opcode[7:0];
  add_lit_a: assert property (g && opcode[13:9] == 5'h1f |=>
    acc_out == 8'($past(acc_out) + $past(k))) else $error("add lit");
  add_carry_a: assert property (g && opcode[13:9] == 5'h1f |=>
    carry_flag == (9'($past(acc_out)) + 9'($past(k)) > 9'h0ff) &&
    digit_carry_flag == (5'($past(acc_out[3:0])) + 5'($past(k[3:0]))
    > 5'h0f)) else $error("add flags");
  and_lit_a: assert property (g && opcode[13:8] == 6'h39 |=>
    acc_out == ($past(acc_out) & $past(k)) && $stable(carry_flag) &&
    zero_flag == (acc_out == 8'h00)) else $error("and lit");
  add_file_a: assert property (g && opcode[13:7] == 7'h0e |=>
    acc_out == 8'($past(acc_out) + $past(file_rdata)) && !file_we)
    else $error("add file");
  and_file_a: assert property (g && opcode[13:7] == 7'h0b |=>
    file_we && file_wdata == ($past(acc_out) & $past(file_rdata)) &&
    $stable(acc_out) && $stable(carry_flag)) else $error("and file");
  clr_bit_a: assert property (g && opcode[13:10] == 4'h4 |=>
    file_we && file_addr == $past(opcode[6:0]) && file_wdata ==
    ($past(file_rdata) & ~(8'h01 << $past(opcode[9:7]))))
    else $error("bit clear");
  clr_flags_a: assert property (op_valid && opcode[13:10] == 4'h4 |=>
    $stable({carry_flag, digit_carry_flag, zero_flag}))
    else $error("bit clear flags");
  apb_ok_a: assert property (psel |-> pready && !pslverr)
    else $error("bus answer");
endmodule
bind acbc_core acbc_core_sva u_sva (.pclk, .presetn, .psel, .pready,
  .pslverr, .opcode, .op_valid, .file_rdata, .file_is_port, .file_addr,
  .file_wdata, .file_we, .acc_out, .carry_flag, .digit_carry_flag,
  .zero_flag);
`default_nettype wire

// ### test/acbc_file_model.sv
// Register file model at the far side
`timescale 1ns/10ps
`default_nettype none
module acbc_file_model (
  input  wire logic       pclk,
  input  wire logic [6:0] rd_addr,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wdata,
  input  wire logic       we,
  output logic      [7:0] rdata
);
  logic [7:0] mem [128];
  // Same-cycle read, as decode hands the operand with the opcode
  assign rdata = mem[rd_addr];
  always @(posedge pclk) begin
    if (we)
      mem[wr_addr] <= wdata;
  end
endmodule
`default_nettype wire

// ### test/tb_acbc_core.sv
// Bench for the execute datapath
`timescale 1ns/10ps
`include "acbc_params.svh"
`default_nettype none
module tb_acbc_core;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        op_valid, file_is_port, file_we;
  logic        carry_flag, digit_carry_flag, zero_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] opcode;
  logic [7:0]  file_rdata, port_pins, file_wdata, acc_out;
  logic [6:0]  file_addr;
  int          err_total, compares, cyc;
  acbc_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .opcode, .op_valid, .file_rdata,
    .file_is_port, .port_pins, .file_addr, .file_wdata, .file_we,
    .acc_out, .carry_flag, .digit_carry_flag, .zero_flag);
  acbc_file_model u_file (.pclk, .rd_addr(opcode[6:0]),
    .wr_addr(file_addr), .wdata(file_wdata), .we(file_we),
    .rdata(file_rdata));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic exec(input logic [13:0] o, input int n);
    @(posedge pclk);
    opcode <= o;
    op_valid <= 1'b1;
    @(posedge pclk);
    op_valid <= 1'b0;
    @(posedge pclk);
    #1;
    $display("test %0d done", n);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, op_valid, file_is_port} = '0;
    paddr = '0;
    pwdata = '0;
    opcode = '0;
    port_pins = 8'h0f;
    u_file.mem[7'h21] = 8'hc2;
    u_file.mem[7'h22] = 8'hc7;
    u_file.mem[7'h05] = 8'hff;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `ACBC_ADDR_ACC, 32'h10);
    exec(14'h3e15, 1);
    chk(acc_out, 8'h25);
    apb(1'b1, `ACBC_ADDR_ACC, 32'h88);
    exec(14'h3e78, 2);
    chk({acc_out, carry_flag, digit_carry_flag, zero_flag}, 11'h007);
    apb(1'b1, `ACBC_ADDR_ACC, 32'ha3);
    exec(14'h395f, 3);
    chk({acc_out, carry_flag, digit_carry_flag, zero_flag}, 11'h01e);
    apb(1'b1, `ACBC_ADDR_ACC, 32'h17);
    exec(14'h0721, 4);
    chk({acc_out, u_file.mem[7'h21]}, 16'hd9c2);
    apb(1'b1, `ACBC_ADDR_ACC, 32'h17);
    exec(14'h05a1, 5);
    chk({acc_out, u_file.mem[7'h21]}, 16'h1702);
    exec(14'h13a2, 6);
    chk({u_file.mem[7'h22], carry_flag, zero_flag}, 10'h11c);
    file_is_port <= 1'b1;
    apb(1'b1, `ACBC_ADDR_ACC, 32'h00);
    exec(14'h0705, 7);
    chk(acc_out, 8'h0f);
    file_is_port <= 1'b0;
    apb(1'b1, `ACBC_ADDR_OPCODE, 32'h3e01);
    apb(1'b1, `ACBC_ADDR_ACC, 32'h41);
    apb(1'b1, `ACBC_ADDR_CTRL, 32'h1);
    apb(1'b0, `ACBC_ADDR_ACC, 32'h0);
    chk(rd, 32'h42);
    apb(1'b0, `ACBC_ADDR_STATUS, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, `ACBC_ADDR_RESULT, 32'h0);
    chk(rd, 32'h0147);
    apb(1'b0, 12'hff0, 32'h0);
    chk(rd, 32'h0);
    $display("test 8 done");
    complete_run();
  end
endmodule
`default_nettype wire
